// ---- pkg/sdc_defs.svh ----
// Field positions, reset values and code points for the switch driver control
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
// Status flag positions (both sides)
`define SDC_CL1_BIT    0
`define SDC_OL1_BIT    1
`define SDC_CL2_BIT    2
`define SDC_OL2_BIT    3
// Interrupt source codes
`define SDC_SRC_NONE   4'h0
`define SDC_SRC_HS     4'h2
`define SDC_SRC_LS     4'h3
// Control and status reset values
`define SDC_CTRL_RST   4'h0
`define SDC_STAT_RST   4'h0
`endif

// ---- pkg/sdc_pkg.sv ----
// Types shared by the switch driver control block
`default_nettype none
package sdc_pkg;
  typedef enum logic [1:0] {
    SDC_NORMAL   = 2'b00,
    SDC_NORM_REQ = 2'b01,
    SDC_STOP     = 2'b10,
    SDC_SLEEP    = 2'b11
  } sdc_mode_t;

  // Control register layout of one side
  typedef struct packed {
    logic two_pulse_select;
    logic one_pulse_select;
    logic two_enable;
    logic one_enable;
  } sdc_ctrl_t;

  // Analog detector inputs of one side
  typedef struct packed {
    logic over_temp;
    logic two_current_limit;
    logic one_current_limit;
    logic two_open_load;
    logic one_open_load;
  } sdc_det_t;
endpackage
`default_nettype wire

// ---- hw/sdc_side.sv ----
// One pair of protected switches: shutdown latch, drive and status
`timescale 1ns/10ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_side
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  // Control
  input  wire sdc_pkg::sdc_ctrl_t ctrl_i,
  input  wire logic              ctrl_wr_i,
  input  wire logic              pulse_i,
  input  wire logic              hv_i,
  input  wire logic              hv_en_i,
  input  wire logic              allow_i,
  input  wire sdc_pkg::sdc_det_t det_i,
  // Results
  output logic [1:0]             drive_o,
  output logic [3:0]             status_o,
  output logic                   therm_evt_o,
  output logic                   shut_o
);
  logic therm_shut;
  logic hv_shut;
  logic ot_prev;
  wire  ot_rise    = det_i.over_temp & ~ot_prev;
  wire  hv_trip    = hv_en_i & hv_i;
  // Write only clears once the cause is gone
  wire  clr_therm  = ctrl_wr_i & ~det_i.over_temp;
  wire  clr_hv     = ctrl_wr_i & ~hv_i;
  wire  shut       = therm_shut | hv_shut;
  wire  on_one     = ctrl_i.one_enable & (~ctrl_i.one_pulse_select | pulse_i);
  wire  on_two     = ctrl_i.two_enable & (~ctrl_i.two_pulse_select | pulse_i);
  wire  [1:0] next_drive = (shut | ~allow_i) ? 2'h0 : {on_two, on_one};
  logic [3:0] next_status;

  always_comb
  begin
    next_status = '0;
    next_status[`SDC_OL1_BIT] = det_i.one_open_load;
    next_status[`SDC_OL2_BIT] = det_i.two_open_load;
    next_status[`SDC_CL1_BIT] = det_i.one_current_limit;
    next_status[`SDC_CL2_BIT] = det_i.two_current_limit;
    if (therm_shut)
    begin
      next_status = 4'hf;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      therm_shut  <= 1'b0;
      hv_shut     <= 1'b0;
      ot_prev     <= 1'b0;
      drive_o     <= 2'h0;
      status_o    <= `SDC_STAT_RST;
      therm_evt_o <= 1'b0;
    end
    else
    begin
      ot_prev     <= det_i.over_temp;
      // Trip wins over a clearing write
      therm_shut  <= det_i.over_temp | (therm_shut & ~clr_therm);
      hv_shut     <= hv_trip | (hv_shut & ~clr_hv);
      drive_o     <= next_drive;
      status_o    <= next_status;
      therm_evt_o <= ot_rise;
    end
  end
  assign shut_o = shut;
endmodule
`default_nettype wire

// ---- hw/sdc_top.sv ----
// Switch driver control: two high side and two low side protected outputs
//
// Function
// - Each high side output follows its own enable bit.
// - High side enable plus pulse select: output follows external pulse input.
// - High side open-load flags per output in status.
// - High side current-limit flags per output while limiting.
// - High side over-temperature shuts both outputs, latches high side event.
// - High side thermal shutdown sets all four high side status flags.
// - Interrupt for high side event only when its mask bit set.
// - High side re-enabled by control write after over-temperature clears.
// - High-voltage with shutdown enable shuts both high side outputs.
// - High side re-enabled by control write after high voltage gone.
// - High side outputs may operate in sleep and stop.
// - Each low side output follows its own enable bit.
// - Low side enable plus pulse select: output follows external pulse input.
// - Low side open-load flags per output in status.
// - Interrupts only in normal, normal-request or stop mode.
// - Masked source keeps interrupt high and sets no source flag.
// - Low side current-limit flags per output.
// - Low side over-temperature: shut, latch, masked irq, rewrite re-enables.
// - High-voltage shutdown also shuts low side until later write.
// - Low side outputs disabled in sleep and stop.
`timescale 1ns/10ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_top
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  // Control registers
  input  wire sdc_pkg::sdc_ctrl_t high_side_control_reg_i,
  input  wire logic              high_side_control_wr_i,
  input  wire sdc_pkg::sdc_ctrl_t low_side_control_reg_i,
  input  wire logic              low_side_control_wr_i,
  input  wire logic              high_voltage_shutdown_enable_i,
  input  wire logic              high_side_irq_mask_i,
  input  wire logic              low_side_irq_mask_i,
  input  wire sdc_pkg::sdc_mode_t mode_i,
  input  wire logic              high_side_cyclic_i,
  input  wire logic              source_read_i,
  // Pins and analog detectors
  input  wire logic              external_pulse_input_i,
  input  wire logic              high_voltage_i,
  input  wire sdc_pkg::sdc_det_t high_det_i,
  input  wire sdc_pkg::sdc_det_t low_det_i,
  // Outputs
  output logic [1:0]             high_drive_o,
  output logic [1:0]             low_drive_o,
  output logic [3:0]             high_side_status_reg_o,
  output logic [3:0]             low_side_status_reg_o,
  output logic [3:0]             interrupt_source_reg_o,
  output logic                   irq_n_o,
  output logic                   high_shut_o,
  output logic                   low_shut_o
);
  // ==========================================================
  // Pin synchronisers: three stages, change taken when 2 and 3 agree
  // ==========================================================
  logic [2:0] pwm_sync;
  logic [2:0] hv_sync;
  logic       pwm_q;
  logic       hv_q;
  wire  next_pwm = (pwm_sync[1] == pwm_sync[2]) ? pwm_sync[2] : pwm_q;
  wire  next_hv  = (hv_sync[1] == hv_sync[2]) ? hv_sync[2] : hv_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      pwm_sync <= 3'h0;
      hv_sync  <= 3'h0;
      pwm_q    <= 1'b0;
      hv_q     <= 1'b0;
    end
    else
    begin
      pwm_sync <= {pwm_sync[1:0], external_pulse_input_i};
      hv_sync  <= {hv_sync[1:0], high_voltage_i};
      pwm_q    <= next_pwm;
      hv_q     <= next_hv;
    end
  end

  // ==========================================================
  // Mode gating
  // ==========================================================
  function automatic logic is_low_power(input sdc_pkg::sdc_mode_t m);
    is_low_power = (m == sdc_pkg::SDC_SLEEP) || (m == sdc_pkg::SDC_STOP);
  endfunction
  wire high_allow = ~is_low_power(mode_i) | high_side_cyclic_i;
  wire low_allow  = ~is_low_power(mode_i);
  wire irq_mode   = (mode_i != sdc_pkg::SDC_SLEEP);

  // ==========================================================
  // Switch sides
  // ==========================================================
  logic high_evt;
  logic low_evt;

  sdc_side u_high
  (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .ctrl_i      (high_side_control_reg_i),
    .ctrl_wr_i   (high_side_control_wr_i),
    .pulse_i     (pwm_q),
    .hv_i        (hv_q),
    .hv_en_i     (high_voltage_shutdown_enable_i),
    .allow_i     (high_allow),
    .det_i       (high_det_i),
    .drive_o     (high_drive_o),
    .status_o    (high_side_status_reg_o),
    .therm_evt_o (high_evt),
    .shut_o      (high_shut_o)
  );

  sdc_side u_low
  (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .ctrl_i      (low_side_control_reg_i),
    .ctrl_wr_i   (low_side_control_wr_i),
    .pulse_i     (pwm_q),
    .hv_i        (hv_q),
    .hv_en_i     (high_voltage_shutdown_enable_i),
    .allow_i     (low_allow),
    .det_i       (low_det_i),
    .drive_o     (low_drive_o),
    .status_o    (low_side_status_reg_o),
    .therm_evt_o (low_evt),
    .shut_o      (low_shut_o)
  );

  // ==========================================================
  // Interrupt source latch; a new event beats the read clear
  // ==========================================================
  wire hs_take = high_evt & high_side_irq_mask_i & irq_mode;
  wire ls_take = low_evt & low_side_irq_mask_i & irq_mode;
  logic [3:0] next_src;

  always_comb
  begin
    next_src = interrupt_source_reg_o;
    if (source_read_i)
    begin
      next_src = `SDC_SRC_NONE;
    end
    // High side has priority when both arrive together
    if (ls_take)
    begin
      next_src = `SDC_SRC_LS;
    end
    if (hs_take)
    begin
      next_src = `SDC_SRC_HS;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      interrupt_source_reg_o <= `SDC_SRC_NONE;
    end
    else
    begin
      interrupt_source_reg_o <= next_src;
    end
  end

  assign irq_n_o = (interrupt_source_reg_o == `SDC_SRC_NONE);

  // ==========================================================
  // Checks
  // ==========================================================
  a_high_shut_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    high_shut_o |=> high_drive_o == 2'h0)
    else $error("high side driven during shutdown");
  a_low_shut_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    low_shut_o |=> low_drive_o == 2'h0)
    else $error("low side driven during shutdown");
  a_high_therm_flags: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    high_det_i.over_temp |=> ##1 high_side_status_reg_o == 4'hf)
    else $error("thermal shutdown flags not all set");
  a_high_therm_latch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    high_det_i.over_temp |=> high_shut_o)
    else $error("high side thermal shutdown not latched");
  a_masked_no_src: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_side_irq_mask_i && !low_side_irq_mask_i && !$past(hs_take) && !source_read_i
     && interrupt_source_reg_o == `SDC_SRC_NONE) |=> irq_n_o)
    else $error("interrupt raised while masked");
  a_hs_irq_raise: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    hs_take |=> !irq_n_o && interrupt_source_reg_o == `SDC_SRC_HS)
    else $error("high side interrupt not raised");
  a_sleep_no_irq: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (mode_i == sdc_pkg::SDC_SLEEP && source_read_i) |=> irq_n_o)
    else $error("interrupt source set in sleep");
  a_low_sleep_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    is_low_power(mode_i) |=> low_drive_o == 2'h0)
    else $error("low side driven in sleep or stop");
  a_hv_trip_hs: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (hv_q && high_voltage_shutdown_enable_i) |=> high_shut_o)
    else $error("high voltage did not shut high side");
  a_hold_until_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (high_shut_o && !high_side_control_wr_i && !$past(high_side_control_wr_i)) |=> high_shut_o)
    else $error("shutdown released without write");

  // ==========================================================
  // Drive, status, shutdown and interrupt checks
  // ==========================================================
  a_high_one_on: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_shut_o && high_allow && high_side_control_reg_i.one_enable
     && !high_side_control_reg_i.one_pulse_select) |=> high_drive_o[0])
    else $error("high side switch one not on");
  a_high_two_on: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_shut_o && high_allow && high_side_control_reg_i.two_enable
     && !high_side_control_reg_i.two_pulse_select) |=> high_drive_o[1])
    else $error("high side switch two not on");
  a_high_one_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_side_control_reg_i.one_enable && high_side_control_reg_i.one_pulse_select)
    |=> !high_drive_o[0])
    else $error("high side switch one on without enable");
  a_high_two_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_side_control_reg_i.two_enable && high_side_control_reg_i.two_pulse_select)
    |=> !high_drive_o[1])
    else $error("high side switch two on without enable");
  a_high_pulse_one: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_shut_o && high_allow && high_side_control_reg_i.one_enable
     && high_side_control_reg_i.one_pulse_select) |=> high_drive_o[0] == $past(pwm_q))
    else $error("high side switch one does not follow pulse input");
  a_high_pulse_two: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_shut_o && high_allow && high_side_control_reg_i.two_enable
     && high_side_control_reg_i.two_pulse_select) |=> high_drive_o[1] == $past(pwm_q))
    else $error("high side switch two does not follow pulse input");
  a_low_one_on: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!low_shut_o && low_allow && low_side_control_reg_i.one_enable
     && !low_side_control_reg_i.one_pulse_select) |=> low_drive_o[0])
    else $error("low side switch one not on");
  a_low_two_on: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!low_shut_o && low_allow && low_side_control_reg_i.two_enable
     && !low_side_control_reg_i.two_pulse_select) |=> low_drive_o[1])
    else $error("low side switch two not on");
  a_low_one_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!low_side_control_reg_i.one_enable && low_side_control_reg_i.one_pulse_select)
    |=> !low_drive_o[0])
    else $error("low side switch one on without enable");
  a_low_two_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!low_side_control_reg_i.two_enable && low_side_control_reg_i.two_pulse_select)
    |=> !low_drive_o[1])
    else $error("low side switch two on without enable");
  a_low_pulse_one: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!low_shut_o && low_allow && low_side_control_reg_i.one_enable
     && low_side_control_reg_i.one_pulse_select) |=> low_drive_o[0] == $past(pwm_q))
    else $error("low side switch one does not follow pulse input");
  a_low_pulse_two: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!low_shut_o && low_allow && low_side_control_reg_i.two_enable
     && low_side_control_reg_i.two_pulse_select) |=> low_drive_o[1] == $past(pwm_q))
    else $error("low side switch two does not follow pulse input");
  a_high_open_load: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !high_shut_o |=> (high_side_status_reg_o[`SDC_OL1_BIT] == $past(high_det_i.one_open_load)
      && high_side_status_reg_o[`SDC_OL2_BIT] == $past(high_det_i.two_open_load)))
    else $error("high side open-load flags wrong");
  a_high_cur_limit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !high_shut_o |=> (high_side_status_reg_o[`SDC_CL1_BIT] == $past(high_det_i.one_current_limit)
      && high_side_status_reg_o[`SDC_CL2_BIT] == $past(high_det_i.two_current_limit)))
    else $error("high side current-limit flags wrong");
  a_low_open_load: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !low_shut_o |=> (low_side_status_reg_o[`SDC_OL1_BIT] == $past(low_det_i.one_open_load)
      && low_side_status_reg_o[`SDC_OL2_BIT] == $past(low_det_i.two_open_load)))
    else $error("low side open-load flags wrong");
  a_low_cur_limit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !low_shut_o |=> (low_side_status_reg_o[`SDC_CL1_BIT] == $past(low_det_i.one_current_limit)
      && low_side_status_reg_o[`SDC_CL2_BIT] == $past(low_det_i.two_current_limit)))
    else $error("low side current-limit flags wrong");
  a_low_therm_flags: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    low_det_i.over_temp |=> ##1 low_side_status_reg_o == 4'hf)
    else $error("low side thermal flags not all set");
  a_low_therm_latch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    low_det_i.over_temp |=> low_shut_o)
    else $error("low side thermal shutdown not latched");
  a_low_therm_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (low_shut_o && low_det_i.over_temp) |=> low_shut_o)
    else $error("low side shutdown lifted while hot");
  a_ls_irq_raise: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (ls_take && !hs_take) |=> !irq_n_o && interrupt_source_reg_o == `SDC_SRC_LS)
    else $error("low side interrupt not raised");
  a_hv_trip_ls: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (hv_q && high_voltage_shutdown_enable_i) |=> low_shut_o)
    else $error("high voltage did not shut low side");
  a_low_hold_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (low_shut_o && !low_side_control_wr_i) |=> low_shut_o)
    else $error("low side shutdown released without write");
  a_high_therm_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (high_shut_o && high_det_i.over_temp) |=> high_shut_o)
    else $error("high side shutdown lifted while hot");
  a_high_write_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (high_side_control_wr_i && !hv_q && !high_det_i.over_temp) |=> !high_shut_o)
    else $error("high side not re-enabled by write");
  a_low_write_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (low_side_control_wr_i && !hv_q && !low_det_i.over_temp) |=> !low_shut_o)
    else $error("low side not re-enabled by write");
  a_high_sleep_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (is_low_power(mode_i) && !high_side_cyclic_i) |=> high_drive_o == 2'h0)
    else $error("high side driven in low power without cyclic sense");
  a_sleep_src_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (mode_i == sdc_pkg::SDC_SLEEP) |=> (interrupt_source_reg_o == $past(interrupt_source_reg_o)
      || interrupt_source_reg_o == `SDC_SRC_NONE))
    else $error("interrupt source set in sleep");
  a_hs_masked_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!high_side_irq_mask_i && interrupt_source_reg_o != `SDC_SRC_HS)
    |=> interrupt_source_reg_o != `SDC_SRC_HS)
    else $error("masked high side source flag set");
  a_ls_masked_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!low_side_irq_mask_i && interrupt_source_reg_o != `SDC_SRC_LS)
    |=> interrupt_source_reg_o != `SDC_SRC_LS)
    else $error("masked low side source flag set");
endmodule
`default_nettype wire

// ---- dv/sdc_mcu_model.sv ----
// Microcontroller model driving the pulse-width pin
`timescale 1ns/10ps
`default_nettype none
module sdc_mcu_model
#(
  parameter int HALF = 16
)
(
  // Clock
  input  wire logic ref_clk_i,
  // Pulse control
  input  wire logic run_i,
  input  wire logic level_i,
  // Pin
  output logic      pulse_o
);
  int cnt = 0;
  // =======================================================
  // Square wave or held level; slow enough to outrun the pin sync
  always_ff @(posedge ref_clk_i)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (!run_i)
      pulse_o <= level_i;
    else if (cnt == HALF - 1)
      pulse_o <= !pulse_o;
  end
endmodule
`default_nettype wire

// ---- dv/sdc_top_tb.sv ----
// Self-checking bench for the switch driver control
`timescale 1ns/10ps
`default_nettype none
module sdc_top_tb;
  logic ref_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  sdc_pkg::sdc_ctrl_t hctl = 4'h0, lctl = 4'h0;
  sdc_pkg::sdc_det_t hdet = 5'h0, ldet = 5'h0;
  sdc_pkg::sdc_mode_t mode = sdc_pkg::SDC_NORMAL;
  logic hwr = 1'h0, lwr = 1'h0, hv_en = 1'h0, hmask = 1'h0, lmask = 1'h0;
  logic cyc = 1'h0, rd = 1'h0, hv = 1'h0, run = 1'h0, lvl = 1'h0, pulse;
  logic [1:0] hdrv, ldrv;
  logic [3:0] hst, lst, src;
  logic irq_n, hshut, lshut;
  int failures = 0, total_checks = 0, cycles = 0;

  sdc_top DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .high_side_control_reg_i(hctl), .high_side_control_wr_i(hwr),
    .low_side_control_reg_i(lctl), .low_side_control_wr_i(lwr),
    .high_voltage_shutdown_enable_i(hv_en), .high_side_irq_mask_i(hmask),
    .low_side_irq_mask_i(lmask), .mode_i(mode), .high_side_cyclic_i(cyc),
    .source_read_i(rd), .external_pulse_input_i(pulse), .high_voltage_i(hv),
    .high_det_i(hdet), .low_det_i(ldet), .high_drive_o(hdrv), .low_drive_o(ldrv),
    .high_side_status_reg_o(hst), .low_side_status_reg_o(lst),
    .interrupt_source_reg_o(src), .irq_n_o(irq_n), .high_shut_o(hshut),
    .low_shut_o(lshut));
  sdc_mcu_model #(.HALF(16)) u_mcu (.ref_clk_i(ref_clk_i), .run_i(run), .level_i(lvl),
    .pulse_o(pulse));

  // =======================================================
  // Helpers
  initial
  begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cycle ceiling well above the whole sequence
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      $display("wrong value cycle limit expected below %0d seen %0d", 5000, cycles);
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  function automatic logic [3:0] drv(input logic hi);
    return hi ? {2'h0, hdrv} : {2'h0, ldrv};
  endfunction
  // Both control registers written with one value
  task automatic wr(input logic [3:0] v);
    @(posedge ref_clk_i);
    hctl <= v;
    lctl <= v;
    hwr <= 1'h1;
    lwr <= 1'h1;
    @(posedge ref_clk_i);
    hwr <= 1'h0;
    lwr <= 1'h0;
  endtask

  // =======================================================
  // Scenarios
  task automatic t_enable();
    for (int p = 0; p < 4; p++)
    begin
      wr(4'(p));
      cyc_n(3);
      chk("high drive", 4'(p), drv(1'h1));
      chk("low drive", 4'(p), drv(1'h0));
    end
  endtask
  task automatic t_pulse();
    wr(4'hc);
    lvl <= 1'h1;
    cyc_n(8);
    chk("high drive", 4'h0, drv(1'h1));
    chk("low drive", 4'h0, drv(1'h0));
    wr(4'hf);
    cyc_n(8);
    chk("high drive", 4'h3, drv(1'h1));
    chk("low drive", 4'h3, drv(1'h0));
    lvl <= 1'h0;
    cyc_n(8);
    chk("high drive", 4'h0, drv(1'h1));
    chk("low drive", 4'h0, drv(1'h0));
    run <= 1'h1;
    @(posedge pulse);
    cyc_n(8);
    chk("high drive", 4'h3, drv(1'h1));
    @(negedge pulse);
    cyc_n(8);
    chk("low drive", 4'h0, drv(1'h0));
    run <= 1'h0;
  endtask
  task automatic t_status();
    logic [3:0] exp [4] = '{4'h2, 4'h8, 4'h1, 4'h4};
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk_i);
      hdet <= 5'h1 << k;
      ldet <= 5'h1 << k;
      cyc_n(3);
      chk("high status", exp[k], hst);
      chk("low status", exp[k], lst);
    end
    hdet <= 5'h0;
    ldet <= 5'h0;
  endtask
  task automatic t_therm(input logic hi, input logic mask, input sdc_pkg::sdc_mode_t m);
    logic [3:0] code;
    code = (mask && m != sdc_pkg::SDC_SLEEP) ? (hi ? 4'h2 : 4'h3) : 4'h0;
    mode <= m;
    cyc <= 1'h1;
    hmask <= mask;
    lmask <= mask;
    wr(4'h3);
    cyc_n(3);
    if (hi)
      hdet.over_temp <= 1'h1;
    else
      ldet.over_temp <= 1'h1;
    cyc_n(3);
    chk("drive", 4'h0, drv(hi));
    chk("status", 4'hf, hi ? hst : lst);
    chk("source", code, src);
    chk("irq", {3'h0, code == 4'h0}, {3'h0, irq_n});
    // Write while still hot must not lift the shutdown
    wr(4'h3);
    cyc_n(3);
    chk("shut", 4'h1, {3'h0, hi ? hshut : lshut});
    hdet.over_temp <= 1'h0;
    ldet.over_temp <= 1'h0;
    cyc_n(4);
    chk("drive", 4'h0, drv(hi));
    wr(4'h3);
    cyc_n(3);
    chk("drive", 4'h3, drv(hi));
    rd <= 1'h1;
    @(posedge ref_clk_i);
    rd <= 1'h0;
    cyc_n(2);
    chk("source", 4'h0, src);
    mode <= sdc_pkg::SDC_NORMAL;
  endtask
  task automatic t_modes();
    for (int m = 2; m < 4; m++)
    begin
      mode <= sdc_pkg::sdc_mode_t'(m);
      cyc <= 1'h1;
      wr(4'h3);
      cyc_n(3);
      chk("high drive", 4'h3, drv(1'h1));
      chk("low drive", 4'h0, drv(1'h0));
      cyc <= 1'h0;
      cyc_n(3);
      chk("high drive", 4'h0, drv(1'h1));
    end
    mode <= sdc_pkg::SDC_NORMAL;
  endtask
  task automatic t_hv();
    wr(4'h3);
    hv_en <= 1'h1;
    hv <= 1'h1;
    cyc_n(8);
    chk("high drive", 4'h0, drv(1'h1));
    chk("low drive", 4'h0, drv(1'h0));
    wr(4'h3);
    cyc_n(3);
    chk("shut", 4'h3, {2'h0, hshut, lshut});
    hv <= 1'h0;
    cyc_n(8);
    wr(4'h3);
    cyc_n(3);
    chk("high drive", 4'h3, drv(1'h1));
    chk("low drive", 4'h3, drv(1'h0));
    hv_en <= 1'h0;
    hv <= 1'h1;
    cyc_n(8);
    chk("high drive", 4'h3, drv(1'h1));
    hv <= 1'h0;
  endtask

  // =======================================================
  // Main sequence
  initial
  begin
    cyc_n(2);
    sys_rst_i <= 1'h0;
    t_enable();
    t_pulse();
    t_status();
    t_therm(1'h1, 1'h1, sdc_pkg::SDC_NORMAL);
    t_therm(1'h0, 1'h1, sdc_pkg::SDC_NORM_REQ);
    t_therm(1'h1, 1'h0, sdc_pkg::SDC_NORMAL);
    t_therm(1'h1, 1'h1, sdc_pkg::SDC_SLEEP);
    t_therm(1'h1, 1'h1, sdc_pkg::SDC_STOP);
    t_modes();
    t_hv();
    report_and_stop();
  end
endmodule
`default_nettype wire
